// ===== sbc_cfg_regs.v
// SPI register bank for PWM duty, PWM rate, protection config and scratch bytes.
`timescale 1ns/1ps
`include "sbc_regs.vh"

module sbc_cfg_regs #(
  parameter DIV_W     = 16,
  parameter STEP_CYC0 = `SBC_STEP_CYC0,
  parameter STEP_CYC1 = `SBC_STEP_CYC1,
  parameter STEP_CYC2 = `SBC_STEP_CYC2,
  parameter STEP_CYC3 = `SBC_STEP_CYC3
) (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       sclk_i,
  input  wire       chip_select_n_i,
  input  wire       mosi_i,
  output reg        miso_o,
  output reg        miso_oe_o,
  input  wire       soft_reset_i,
  input  wire       normal_mode_i,
  input  wire       cfg_lock_bit_i,
  input  wire [2:0] pin_config_i,
  output reg        high_side_switch_o,
  output reg        low_side_switch_o,
  output wire       thermal_trip_level_o,
  output wire [1:0] supply_current_limit_code_o,
  output wire       lock_active_o
);

  // ==========================================================================
  // Pin synchronisers
  // Stage one of each chain feeds stage two only; edges are found on
  // stages two and three.
  reg  [2:0] sclk_sync;
  reg  [2:0] cs_sync;
  reg  [1:0] mosi_sync;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_sync <= 3'h0;
      cs_sync   <= 3'h7;
      mosi_sync <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk_i};
      cs_sync   <= {cs_sync[1:0], chip_select_n_i};
      mosi_sync <= {mosi_sync[0], mosi_i};
    end
  end

  wire sclk_rise = sclk_sync[1] && !sclk_sync[2];
  wire sclk_fall = !sclk_sync[1] && sclk_sync[2];
  wire cs_fall   = !cs_sync[1] && cs_sync[2];
  wire cs_rise   = cs_sync[1] && !cs_sync[2];
  wire cs_active = !cs_sync[1];
  wire mosi_s    = mosi_sync[1];

  // ==========================================================================
  // Register storage
  reg  [7:0] pwm_duty_level;
  reg  [1:0] pwm_period_rate;
  reg        thermal_trip_level;
  reg  [1:0] supply_current_limit_code;
  reg  [7:0] scratch_low_byte;
  reg  [7:0] scratch_high_byte;
  reg        lock_active;

  // Read value of an address; unmapped and reserved bits give zero.
  function [7:0] reg_read;
    input [6:0] addr;
    begin
      case (addr)
        `SBC_ADDR_PWM_DUTY:   reg_read = pwm_duty_level;
        `SBC_ADDR_PWM_RATE:   reg_read = {6'h00, pwm_period_rate};
        `SBC_ADDR_HW_PROT:    reg_read = {5'h00, thermal_trip_level,
                                          supply_current_limit_code};
        `SBC_ADDR_SCRATCH_LO: reg_read = scratch_low_byte;
        `SBC_ADDR_SCRATCH_HI: reg_read = scratch_high_byte;
        default:              reg_read = 8'h00;
      endcase
    end
  endfunction

  // ==========================================================================
  // SPI frame engine
  // Bits travel least significant first: address bits 0-6, the access
  // mode bit 7, then data bits 8-15. The first returned byte is zero;
  // the second carries the addressed register's value before any write.
  reg  [15:0] rx_shift;
  reg  [4:0]  bit_cnt;
  reg  [6:0]  tx_shift;
  reg  [15:0] next_rx;

  always @* begin
    next_rx = {mosi_s, rx_shift[15:1]};
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_shift  <= 16'h0000;
      bit_cnt   <= 5'd0;
      tx_shift  <= 7'h00;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      miso_oe_o <= cs_active;
      if (cs_fall) begin
        bit_cnt  <= 5'd0;
        tx_shift <= 7'h00;
        miso_o   <= 1'b0;
      end else if (cs_active) begin
        if (sclk_rise) begin
          rx_shift <= next_rx;
          // Counter saturates so over-long frames stay recognisable.
          if (bit_cnt != 5'h1F) begin
            bit_cnt <= bit_cnt + 5'd1;
          end
        end
        if (sclk_fall) begin
          if (bit_cnt == `SBC_ADDR_BITS_DONE) begin
            {tx_shift, miso_o} <= reg_read(rx_shift[14:8]);
          end else begin
            miso_o   <= tx_shift[0];
            tx_shift <= {1'b0, tx_shift[6:1]};
          end
        end
      end
    end
  end

  // A write commits only at chip select release and only for exact frames,
  // so a frame cut short never leaves a half-written register.
  wire        frame_ok  = cs_rise && (bit_cnt == `SBC_FRAME_BITS);
  wire        wr_frame  = frame_ok && rx_shift[`SBC_MODE_BIT];
  wire [6:0]  wr_addr   = rx_shift[6:0];
  wire [7:0]  wr_data   = rx_shift[15:8];

  function wr_hit;
    input [6:0] addr;
    begin
      wr_hit = wr_frame && (wr_addr == addr);
    end
  endfunction

  // ==========================================================================
  // Configuration lock
  // lock engages at chip select rise.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_active <= 1'b0;
    end else if (cs_rise && cfg_lock_bit_i) begin
      lock_active <= 1'b1;
    end
  end

  // ==========================================================================
  // PWM setting registers
  // Restart does not touch these; only power-on and soft reset clear them.
  // clear on power-on and soft reset.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_duty_level  <= `SBC_RST_PWM_DUTY;
      pwm_period_rate <= `SBC_RST_PWM_RATE;
    end else if (soft_reset_i) begin
      pwm_duty_level  <= `SBC_RST_PWM_DUTY;
      pwm_period_rate <= `SBC_RST_PWM_RATE;
    end else begin
      if (wr_hit(`SBC_ADDR_PWM_DUTY)) begin
        pwm_duty_level <= wr_data;
      end
      if (wr_hit(`SBC_ADDR_PWM_RATE)) begin
        pwm_period_rate <= wr_data[1:0];
      end
    end
  end

  // ==========================================================================
  // Protection configuration register
  // power-up value and locked soft reset.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      thermal_trip_level        <= `SBC_RST_THERMAL;
      supply_current_limit_code <= `SBC_RST_ILIM;
    end else if (soft_reset_i) begin
      if (!lock_active) begin
        thermal_trip_level        <= `SBC_RST_THERMAL;
        supply_current_limit_code <= `SBC_RST_ILIM;
      end
    end else if (wr_hit(`SBC_ADDR_HW_PROT) && !lock_active) begin
      thermal_trip_level        <= wr_data[`SBC_HW_THERMAL_BIT];
      supply_current_limit_code <= wr_data[`SBC_HW_ILIM_MSB:`SBC_HW_ILIM_LSB];
    end
  end

  assign thermal_trip_level_o        = thermal_trip_level;
  // code passes to regulator; code 11 is accepted though discouraged.
  assign supply_current_limit_code_o = supply_current_limit_code;
  assign lock_active_o               = lock_active;

  // ==========================================================================
  // Host scratch bytes
  // These are cleared only by power-on reset; no restart or soft reset input
  // reaches them, normal_mode_i gates their writes, and only the SPI read path reads them.
  // power-on only.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scratch_low_byte  <= `SBC_RST_SCRATCH;
      scratch_high_byte <= `SBC_RST_SCRATCH;
    end else if (normal_mode_i) begin
      if (wr_hit(`SBC_ADDR_SCRATCH_LO)) begin
        scratch_low_byte <= wr_data;
      end
      if (wr_hit(`SBC_ADDR_SCRATCH_HI)) begin
        scratch_high_byte <= wr_data;
      end
    end
  end

  // ==========================================================================
  // PWM generator and pin switch selection
  wire pwm_level;

  sbc_pwm #(
    .DIV_W     (DIV_W),
    .STEP_CYC0 (STEP_CYC0),
    .STEP_CYC1 (STEP_CYC1),
    .STEP_CYC2 (STEP_CYC2),
    .STEP_CYC3 (STEP_CYC3)
  ) u_pwm (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .duty_i       (pwm_duty_level),
    .rate_i       (pwm_period_rate),
    .pwm_o        (pwm_level),
    .period_end_o ()
  );

  // route PWM to low or high side.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_side_switch_o <= 1'b0;
      low_side_switch_o  <= 1'b0;
    end else begin
      high_side_switch_o <= pwm_level && (pin_config_i == `SBC_PIN_PWM_HIGH);
      low_side_switch_o  <= pwm_level && (pin_config_i == `SBC_PIN_PWM_LOW);
    end
  end

endmodule // sbc_cfg_regs

// ===== sbc_cfg_regs_asserts.sv
// Port-level assertions for the configuration register bank.
`timescale 1ns/1ps
module sbc_cfg_asserts (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       sclk_i,
  input wire logic       chip_select_n_i,
  input wire logic       mosi_i,
  input wire logic       miso_o,
  input wire logic       miso_oe_o,
  input wire logic       soft_reset_i,
  input wire logic       normal_mode_i,
  input wire logic       cfg_lock_bit_i,
  input wire logic [2:0] pin_config_i,
  input wire logic       high_side_switch_o,
  input wire logic       low_side_switch_o,
  input wire logic       thermal_trip_level_o,
  input wire logic [1:0] supply_current_limit_code_o,
  input wire logic       lock_active_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================================
  // Sequences
  sequence s_cs_rise; $rose(chip_select_n_i); endsequence
  sequence s_cs_fall; $fell(chip_select_n_i); endsequence
  sequence s_pin_low; (pin_config_i == 3'h6) [*3]; endsequence
  sequence s_pin_high; (pin_config_i == 3'h7) [*3]; endsequence
  sequence s_pin_off; (pin_config_i[2:1] != 2'h3) [*3]; endsequence
  // ==========================================================================
  // Assertions
  a_oe_release: assert property (s_cs_rise |-> ##[1:5] !miso_oe_o)
    else $error("output enable still on after deselect");
  a_oe_engage: assert property (s_cs_fall |-> ##[1:5] miso_oe_o)
    else $error("output enable missing in frame");
  a_first_zero: assert property ($rose(miso_oe_o) |-> !miso_o)
    else $error("first returned bit not zero");
  a_pin_gate: assert property (s_pin_off |-> !high_side_switch_o && !low_side_switch_o)
    else $error("switch on outside pwm pin mode");
  a_low_only: assert property (s_pin_low |-> !high_side_switch_o)
    else $error("high side on in low side mode");
  a_high_only: assert property (s_pin_high |-> !low_side_switch_o)
    else $error("low side on in high side mode");
  a_reset_prot: assert property ($rose(rst_n_i) |->
    supply_current_limit_code_o == 2'h1 && !thermal_trip_level_o && !lock_active_o)
    else $error("protection fields wrong after power-on");
  a_soft_prot: assert property (soft_reset_i && !lock_active_o |=>
    supply_current_limit_code_o == 2'h1 && !thermal_trip_level_o)
    else $error("unlocked soft reset did not restore protection");
  a_lock_sticky: assert property (lock_active_o |=> lock_active_o)
    else $error("lock released without power-on");
  a_lock_freeze: assert property (lock_active_o && $past(lock_active_o) |->
    $stable(thermal_trip_level_o) && $stable(supply_current_limit_code_o))
    else $error("locked protection field changed");
  a_lock_cause: assert property ($rose(lock_active_o) |-> $past(cfg_lock_bit_i))
    else $error("lock engaged without lock bit");
endmodule // sbc_cfg_asserts

bind sbc_cfg_regs sbc_cfg_asserts sbc_cfg_asserts_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
  .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .soft_reset_i(soft_reset_i),
  .normal_mode_i(normal_mode_i), .cfg_lock_bit_i(cfg_lock_bit_i),
  .pin_config_i(pin_config_i), .high_side_switch_o(high_side_switch_o),
  .low_side_switch_o(low_side_switch_o), .thermal_trip_level_o(thermal_trip_level_o),
  .supply_current_limit_code_o(supply_current_limit_code_o), .lock_active_o(lock_active_o));

// ===== sbc_pwm.v
// PWM generator with period-aligned update of duty and rate.
`timescale 1ns/1ps
`include "sbc_regs.vh"

module sbc_pwm #(
  parameter DIV_W     = 16,
  parameter STEP_CYC0 = `SBC_STEP_CYC0,
  parameter STEP_CYC1 = `SBC_STEP_CYC1,
  parameter STEP_CYC2 = `SBC_STEP_CYC2,
  parameter STEP_CYC3 = `SBC_STEP_CYC3
) (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire [7:0] duty_i,
  input  wire [1:0] rate_i,
  output reg        pwm_o,
  output wire       period_end_o
);

  reg  [DIV_W-1:0] div_cnt;
  reg  [7:0]       step;
  reg  [7:0]       duty_act;
  reg  [1:0]       rate_act;
  reg  [DIV_W-1:0] div_last;
  wire             step_tick;

  // ==========================================================================
  // Step pacing
  // rate code to step length.
  always @* begin
    case (rate_act)
      2'h0:    div_last = STEP_CYC0[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
      2'h1:    div_last = STEP_CYC1[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
      2'h2:    div_last = STEP_CYC2[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
      default: div_last = STEP_CYC3[DIV_W-1:0] - {{(DIV_W-1){1'b0}}, 1'b1};
    endcase
  end

  assign step_tick    = (div_cnt == div_last);
  assign period_end_o = step_tick && (step == `SBC_STEP_LAST);

  // ==========================================================================
  // Step counter and period latch
  // step counter per period.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt  <= {DIV_W{1'b0}};
      step     <= 8'h00;
      duty_act <= `SBC_RST_PWM_DUTY;
      rate_act <= `SBC_RST_PWM_RATE;
      pwm_o    <= 1'b0;
    end else begin
      if (step_tick) begin
        div_cnt <= {DIV_W{1'b0}};
      end else begin
        div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      end
      if (period_end_o) begin
        step     <= 8'h00;
        duty_act <= duty_i;
        rate_act <= rate_i;
      end else if (step_tick) begin
        step <= step + 8'h01;
      end
      // duty compare; 255 steps make 0xFF always on.
      pwm_o <= (step < duty_act);
    end
  end

endmodule // sbc_pwm

// ===== sbc_regs.vh
// Constants for the PWM and configuration register group of the supply chip.
// Notes on behaviour
// - Duty zero keeps the selected switch off for the whole period.
// - Duty all ones keeps the selected switch on with no off interval.
// - Intermediate duty turns the switch on for duty/255 of each period.
// - A new duty value applies only after the running period has ended.
// - Rate code 00/01/10/11 selects 100/200/325/400 Hz repetition.
// - A new rate code applies only after the running period has ended.
// - Unused upper bits ignore writes and read back as zero.
// - Duty and rate clear on power-on and soft reset, keep over restart.
// - Thermal bit two clear selects default threshold, set selects higher one.
// - Current limit code 00 down, 01 default, 10 up, 11 two up.
// - Protection register powers up 0x01; soft reset keeps it while locked.
// - Low scratch byte clears at power-up only, survives soft reset.
// - Scratch writes accepted only in Normal mode, ignored otherwise.
// - Scratch bytes survive fail-safe, restart and soft reset.
// - Internal logic never reads or acts on the scratch bytes.
// - High scratch byte behaves like the low one, bits 15 to 8.
// - Lock takes effect at chip select rise and holds until power-up.
// - Each access is a 16-bit frame: address and mode, then data.
// - PWM drives low side at pin code 110, high side at 111.
`ifndef SBC_REGS_VH
`define SBC_REGS_VH

// ==========================================================================
// Register addresses (7-bit SPI addresses)
`define SBC_ADDR_PWM_DUTY     7'h18
`define SBC_ADDR_PWM_RATE     7'h1C
`define SBC_ADDR_HW_PROT      7'h1D
`define SBC_ADDR_SCRATCH_LO   7'h1E
`define SBC_ADDR_SCRATCH_HI   7'h1F

// ==========================================================================
// Reset values and fields
`define SBC_RST_PWM_DUTY      8'h00
`define SBC_RST_PWM_RATE      2'h0
`define SBC_RST_SCRATCH       8'h00
`define SBC_RST_THERMAL       1'h0
`define SBC_RST_ILIM          2'h1
`define SBC_HW_THERMAL_BIT    2
`define SBC_HW_ILIM_MSB       1
`define SBC_HW_ILIM_LSB       0
`define SBC_DUTY_FULL         8'hFF

// ==========================================================================
// SPI frame layout
`define SBC_FRAME_BITS        5'd16
`define SBC_ADDR_BITS_DONE    5'd8
`define SBC_MODE_BIT          7
`define SBC_PIN_PWM_LOW       3'h6
`define SBC_PIN_PWM_HIGH      3'h7

// ==========================================================================
// PWM timing
`define SBC_CLK_HZ            125000000
`define SBC_PWM_STEPS         255
`define SBC_STEP_LAST         8'hFE
`define SBC_RATE0_HZ          100
`define SBC_RATE1_HZ          200
`define SBC_RATE2_HZ          325
`define SBC_RATE3_HZ          400
`define SBC_STEP_CYC0         (`SBC_CLK_HZ / (`SBC_RATE0_HZ * `SBC_PWM_STEPS))
`define SBC_STEP_CYC1         (`SBC_CLK_HZ / (`SBC_RATE1_HZ * `SBC_PWM_STEPS))
`define SBC_STEP_CYC2         (`SBC_CLK_HZ / (`SBC_RATE2_HZ * `SBC_PWM_STEPS))
`define SBC_STEP_CYC3         (`SBC_CLK_HZ / (`SBC_RATE3_HZ * `SBC_PWM_STEPS))

`endif

// ===== sbc_spi_host.sv
// Behavioural host controller acting as master on the register bank's serial port.
`timescale 1ns/1ps
module sbc_spi_host (
  input  wire logic mclk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      chip_select_n_o,
  output logic      mosi_o
);
  initial begin
    sclk_o          = 1'b0;
    chip_select_n_o = 1'b1;
    mosi_o          = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // ==========================================================================
  // Frame transfer
  // address byte then data
  task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d,
                      input int nb, input int hp, output logic [7:0] q);
    logic [15:0] f;
    logic [15:0] rx;
    f  = {d, wr, a};
    rx = 16'h0000;
    chip_select_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      mosi_o = f[i % 16];
      cyc(hp);
      sclk_o = 1'b1;
      rx[i % 16] = miso_i;
      cyc(hp);
      sclk_o = 1'b0;
    end
    cyc(hp);
    chip_select_n_o = 1'b1;
    // The line is floating once deselected, so it must not keep the last bit.
    mosi_o = ~mosi_o;
    cyc(8);
    q = rx[15:8];
  endtask
endmodule // sbc_spi_host

// ===== sbc_tb.sv
// Self-checking bench for the PWM and configuration register bank.
`timescale 1ns/1ps
`include "sbc_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, g, e); end end
module testbench;
  logic       mclk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       sclk_i, chip_select_n_i, mosi_i, miso_o, miso_oe_o;
  logic       soft_reset_i = 1'b0;
  logic       normal_mode_i = 1'b1;
  logic       cfg_lock_bit_i = 1'b0;
  logic [2:0] pin_config_i = 3'h0;
  logic       high_side_switch_o, low_side_switch_o, thermal_trip_level_o, lock_active_o;
  logic [1:0] supply_current_limit_code_o;
  int         err_total = 0;
  int         comparisons = 0;
  logic [7:0] q;
  logic [7:0] shadow [5];
  logic [6:0] addr_tab [5] = '{`SBC_ADDR_PWM_DUTY, `SBC_ADDR_PWM_RATE, `SBC_ADDR_HW_PROT,
                               `SBC_ADDR_SCRATCH_LO, `SBC_ADDR_SCRATCH_HI};
  logic [7:0] mask_tab [5] = '{8'hFF, 8'h03, 8'h07, 8'hFF, 8'hFF};

  always #4 mclk_i = ~mclk_i;

  // Short step lengths keep a full period between 510 and 1275 cycles.
  sbc_cfg_regs #(.STEP_CYC0(2), .STEP_CYC1(3), .STEP_CYC2(4), .STEP_CYC3(5)) sbc_cfg_regs_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i), .chip_select_n_i(chip_select_n_i),
    .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .soft_reset_i(soft_reset_i),
    .normal_mode_i(normal_mode_i), .cfg_lock_bit_i(cfg_lock_bit_i),
    .pin_config_i(pin_config_i), .high_side_switch_o(high_side_switch_o),
    .low_side_switch_o(low_side_switch_o), .thermal_trip_level_o(thermal_trip_level_o),
    .supply_current_limit_code_o(supply_current_limit_code_o), .lock_active_o(lock_active_o));
  sbc_spi_host sbc_spi_host_inst (.mclk_i(mclk_i), .miso_i(miso_o), .sclk_o(sclk_i),
    .chip_select_n_o(chip_select_n_i), .mosi_o(mosi_i));

  // ==========================================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    sbc_spi_host_inst.xfer(a, 1'b1, d, 16, 5, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    sbc_spi_host_inst.xfer(a, 1'b0, 8'h00, 16, 5, q);
    `CHK(q, e)
  endtask
  task automatic soft_pulse;
    soft_reset_i = 1'b1;
    cyc(1);
    soft_reset_i = 1'b0;
    cyc(1);
  endtask
  function automatic int on_cycles(input logic [7:0] d, input int r);
    return int'(d) * (2 + r);
  endfunction
  task automatic test_done;
    if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [7:0] d;
    int         hc;
    int         lc;
    void'($urandom(32'h0B65));
    repeat (6) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    cyc(4);
    for (int i = 0; i < 5; i++) rd(addr_tab[i], (i == 2) ? 8'h01 : 8'h00);
    for (int i = 0; i < 5; i++) begin
      shadow[i] = 8'($urandom());
      wr(addr_tab[i], shadow[i]);
      rd(addr_tab[i], shadow[i] & mask_tab[i]);
    end
    `CHK({thermal_trip_level_o, supply_current_limit_code_o}, shadow[2][2:0])
    for (int c = 0; c < 4; c++) begin
      wr(addr_tab[2], 8'(c));
      `CHK(supply_current_limit_code_o, 2'(c))
    end
    wr(7'h20, 8'hA5);
    rd(7'h20, 8'h00);
    sbc_spi_host_inst.xfer(addr_tab[0], 1'b1, ~shadow[0], 12, 8, q);
    rd(addr_tab[0], shadow[0]);
    // scratch write outside Normal mode is ignored
    normal_mode_i = 1'b0;
    wr(addr_tab[3], ~shadow[3]);
    rd(addr_tab[3], shadow[3]);
    normal_mode_i = 1'b1;
    soft_pulse();
    for (int i = 0; i < 5; i++) rd(addr_tab[i], (i < 2) ? 8'h00 : (i == 2) ? 8'h01 : shadow[i]);
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 3; k++) begin
        d = (k == 0) ? 8'h00 : (k == 1) ? `SBC_DUTY_FULL : 8'($urandom_range(1, 254));
        pin_config_i = 3'h0;
        wr(addr_tab[0], d);
        wr(addr_tab[1], 8'(r));
        pin_config_i = r[0] ? `SBC_PIN_PWM_HIGH : `SBC_PIN_PWM_LOW;
        cyc(2600);
        hc = 0;
        lc = 0;
        repeat (255 * (2 + r)) begin
          @(posedge mclk_i);
          hc += int'(high_side_switch_o);
          lc += int'(low_side_switch_o);
        end
        #1;
        `CHK(r[0] ? hc : lc, on_cycles(d, r))
        `CHK(r[0] ? lc : hc, 0)
      end
    end
    // mid-period writes wait for the boundary
    wr(addr_tab[0], 8'h20);
    cyc(2600);
    @(posedge high_side_switch_o);
    #1;
    hc = 0;
    fork
      begin
        wr(addr_tab[0], 8'hF0);
        wr(addr_tab[1], 8'h00);
      end
      repeat (255 * 5) begin
        @(posedge mclk_i);
        hc += int'(high_side_switch_o);
      end
    join
    #1;
    `CHK(hc, on_cycles(8'h20, 3))
    hc = 0;
    repeat (255 * 2) begin
      @(posedge mclk_i);
      hc += int'(high_side_switch_o);
    end
    #1;
    `CHK(hc, on_cycles(8'hF0, 0))
    cfg_lock_bit_i = 1'b1;
    wr(addr_tab[2], 8'h06);
    `CHK(lock_active_o, 1'b1)
    wr(addr_tab[2], 8'h01);
    soft_pulse();
    rd(addr_tab[2], 8'h06);
    `CHK({thermal_trip_level_o, supply_current_limit_code_o}, 3'h6)
    test_done();
  end

  initial begin
    repeat (80000) @(posedge mclk_i);
    err_total++;
    test_done();
  end
endmodule // testbench
